// >>> src/dcwd_pkg.sv
// Package for the configuration word decoder: field positions, encodings,
// decoded-setting structs.
// Assumes the three words come from nonvolatile storage, stable during reset.
`default_nettype none

package dcwd_pkg;

  // Word one field positions
  localparam int unsigned W1_SRC_LSB     = 0;
  localparam int unsigned W1_SOSC_BIT    = 5;
  localparam int unsigned W1_TWOSPD_BIT  = 7;
  localparam int unsigned W1_POSC_LSB    = 8;
  localparam int unsigned W1_CLKOUT_N_BIT = 10;
  localparam int unsigned W1_PBDIV_LSB   = 12;
  localparam int unsigned W1_CKSM_LSB    = 14;

  // Word two field positions
  localparam int unsigned W2_PLLMUL_LSB  = 4;
  localparam int unsigned W2_UPLLIDV_LSB = 8;
  localparam int unsigned W2_UPLLBYP_BIT = 15;
  localparam int unsigned W2_PLLODIV_LSB = 16;

  // Word three field positions
  localparam int unsigned W3_UID_LSB     = 0;
  localparam int unsigned W3_PMDLOCK_BIT = 28;
  localparam int unsigned W3_PPSLOCK_BIT = 29;
  localparam int unsigned W3_IDPIN_BIT   = 30;
  localparam int unsigned W3_BUSPWR_BIT  = 31;
  localparam logic [31:0] W3_IMPL_MASK   = 32'hF000FFFF;

  // Latched word values after reset, before the first capture
  localparam logic [31:0] WORD_RESET     = 32'hFFFFFFFF;
  localparam logic [31:0] WORD3_RESET    = 32'hF000FFFF;

  // Primary oscillator modes
  localparam logic [1:0] POSC_EXT_CLOCK  = 2'h0;
  localparam logic [1:0] POSC_STD_XTAL   = 2'h1;
  localparam logic [1:0] POSC_FAST_XTAL  = 2'h2;
  localparam logic [1:0] POSC_DISABLED   = 2'h3;

  typedef enum logic [2:0] {
    DCWD_SRC_FAST_RC     = 3'h0,
    DCWD_SRC_RC_DIV_PLL  = 3'h1,
    DCWD_SRC_PRIMARY     = 3'h2,
    DCWD_SRC_PRIMARY_PLL = 3'h3,
    DCWD_SRC_SECONDARY   = 3'h4,
    DCWD_SRC_LOW_POWER   = 3'h5,
    DCWD_SRC_RC_DIV16    = 3'h6,
    DCWD_SRC_RC_DIV_N    = 3'h7
  } dcwd_src_t;

  // Decoded clock settings
  typedef struct packed {
    dcwd_src_t   startup_clock_source;
    logic [1:0]  primary_osc_mode;
    logic        secondary_osc_enable;
    logic        two_speed_startup_enable;
    logic        clock_switch_enable;
    logic        fail_safe_monitor_enable;
    logic [3:0]  periph_bus_divisor;        // 1, 2, 4 or 8
    logic        clock_out_active;
  } dcwd_clk_cfg_t;

  // Decoded PLL settings
  typedef struct packed {
    logic [8:0]  main_pll_out_divisor;      // 1 to 256
    logic [4:0]  main_pll_multiplier;       // 15 to 24
    logic        usb_pll_enable;
    logic [3:0]  usb_pll_input_divider;     // 1 to 12
  } dcwd_pll_cfg_t;

  // Decoded pin ownership, locks and identifier
  typedef struct packed {
    logic        bus_power_pin_usb;
    logic        usb_id_pin_usb;
    logic        pin_select_one_shot_lock;
    logic        module_disable_one_shot_lock;
    logic [15:0] user_identifier;
  } dcwd_pin_cfg_t;

endpackage : dcwd_pkg

`default_nettype wire

// >>> src/dcwd_decode.sv
// Configuration word latch and decoder: captures three stored words on reset release
// and presents decoded, read-only start-up settings.
// Assumes word inputs are synchronous to clk and stable while rst is high.
`default_nettype none

module dcwd_decode
  import dcwd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [31:0]   nvm_word_one,
  input  wire logic [31:0]   nvm_word_two,
  input  wire logic [31:0]   nvm_word_three,
  output logic [31:0]        clock_config_word_one,
  output logic [31:0]        pll_config_word_two,
  output logic [31:0]        pin_and_user_config_word_three,
  output logic               config_valid,
  output dcwd_clk_cfg_t      clk_cfg,
  output dcwd_pll_cfg_t      pll_cfg,
  output dcwd_pin_cfg_t      pin_cfg,
  output logic               primary_source_conflict,
  output logic [15:0]        user_identifier
);

  logic       capture_done;
  logic [1:0] pbdiv_field;
  logic [2:0] odiv_field;
  logic [2:0] mul_field;
  logic [2:0] uidiv_field;
  logic [1:0] cksm_field;
  logic [1:0] posc_field;
  dcwd_clk_cfg_t next_clk_cfg;
  dcwd_pll_cfg_t next_pll_cfg;
  dcwd_pin_cfg_t next_pin_cfg;

  // Capture once, on the first edge after reset release; later changes to
  // the storage image are ignored so consumers never see a setting move.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_done <= 1'b0;
    end else begin
      capture_done <= 1'b1;
    end
  end

  // Word latches; third word drops its unimplemented bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_config_word_one          <= WORD_RESET;
      pll_config_word_two            <= WORD_RESET;
      pin_and_user_config_word_three <= WORD3_RESET;
    end else if (!capture_done) begin
      clock_config_word_one          <= nvm_word_one;
      pll_config_word_two            <= nvm_word_two;
      pin_and_user_config_word_three <= nvm_word_three & W3_IMPL_MASK;
    end
  end

  assign config_valid = capture_done;

  // Field extraction from latched words
  assign cksm_field  = clock_config_word_one[W1_CKSM_LSB +: 2];
  assign pbdiv_field = clock_config_word_one[W1_PBDIV_LSB +: 2];
  assign posc_field  = clock_config_word_one[W1_POSC_LSB +: 2];
  assign odiv_field  = pll_config_word_two[W2_PLLODIV_LSB +: 3];
  assign mul_field   = pll_config_word_two[W2_PLLMUL_LSB +: 3];
  assign uidiv_field = pll_config_word_two[W2_UPLLIDV_LSB +: 3];

  // Clock settings decode
  always_comb begin
    next_clk_cfg.startup_clock_source     = dcwd_src_t'(clock_config_word_one[W1_SRC_LSB +: 3]);
    next_clk_cfg.primary_osc_mode         = posc_field;
    next_clk_cfg.secondary_osc_enable     = clock_config_word_one[W1_SOSC_BIT];
    next_clk_cfg.two_speed_startup_enable = clock_config_word_one[W1_TWOSPD_BIT];
    next_clk_cfg.clock_switch_enable      = ~cksm_field[1];
    next_clk_cfg.fail_safe_monitor_enable = (cksm_field == 2'h0);
    next_clk_cfg.periph_bus_divisor       = 4'(4'h1 << pbdiv_field);
    // Clock out needs the oscillator output pin free of a crystal
    next_clk_cfg.clock_out_active         = ~clock_config_word_one[W1_CLKOUT_N_BIT] &
                                            ((posc_field == POSC_DISABLED) ||
                                             (posc_field == POSC_EXT_CLOCK));
  end

  // PLL settings decode
  always_comb begin
    case (odiv_field)
      3'h7:    next_pll_cfg.main_pll_out_divisor = 9'h100;
      3'h6:    next_pll_cfg.main_pll_out_divisor = 9'h040;
      default: next_pll_cfg.main_pll_out_divisor = 9'(9'h001 << odiv_field);
    endcase
    case (mul_field)
      3'h7:    next_pll_cfg.main_pll_multiplier = 5'h18;
      default: next_pll_cfg.main_pll_multiplier = 5'(5'h0F + {2'h0, mul_field});
    endcase
    next_pll_cfg.usb_pll_enable = ~pll_config_word_two[W2_UPLLBYP_BIT];
    case (uidiv_field)
      3'h6:    next_pll_cfg.usb_pll_input_divider = 4'hA;
      3'h7:    next_pll_cfg.usb_pll_input_divider = 4'hC;
      default: next_pll_cfg.usb_pll_input_divider = 4'({1'b0, uidiv_field} + 4'h1);
    endcase
  end

  // Pin ownership, locks and identifier decode
  always_comb begin
    next_pin_cfg.bus_power_pin_usb            = pin_and_user_config_word_three[W3_BUSPWR_BIT];
    next_pin_cfg.usb_id_pin_usb               = pin_and_user_config_word_three[W3_IDPIN_BIT];
    next_pin_cfg.pin_select_one_shot_lock     = pin_and_user_config_word_three[W3_PPSLOCK_BIT];
    next_pin_cfg.module_disable_one_shot_lock = pin_and_user_config_word_three[W3_PMDLOCK_BIT];
    next_pin_cfg.user_identifier              = pin_and_user_config_word_three[W3_UID_LSB +: 16];
  end

  // Decoded outputs registered so consumers see flip-flop data only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_cfg <= '0;
      pll_cfg <= '0;
      pin_cfg <= '0;
    end else begin
      clk_cfg <= next_clk_cfg;
      pll_cfg <= next_pll_cfg;
      pin_cfg <= next_pin_cfg;
    end
  end

  // Flag a bad image: primary chosen while the primary is disabled.
  // Not corrected here; the programmer is expected to avoid it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      primary_source_conflict <= 1'b0;
    end else begin
      primary_source_conflict <= (posc_field == POSC_DISABLED) &&
        ((next_clk_cfg.startup_clock_source == DCWD_SRC_PRIMARY) ||
         (next_clk_cfg.startup_clock_source == DCWD_SRC_PRIMARY_PLL));
    end
  end

  // Identifier view for the serial programming and test ports
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      user_identifier <= 16'h0000;
    end else begin
      user_identifier <= pin_and_user_config_word_three[W3_UID_LSB +: 16];
    end
  end

endmodule : dcwd_decode

`default_nettype wire

// >>> test/dcwd_decode_monitor.sv
// Checker for the configuration word decoder: capture timing and field decode.
// Assumes it is bound onto dcwd_decode and sees only that module's ports.
`default_nettype none
module dcwd_decode_monitor
  import dcwd_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic [31:0]   nvm_word_one,
  input wire logic [31:0]   nvm_word_two,
  input wire logic [31:0]   nvm_word_three,
  input wire logic [31:0]   clock_config_word_one,
  input wire logic [31:0]   pll_config_word_two,
  input wire logic [31:0]   pin_and_user_config_word_three,
  input wire logic          config_valid,
  input wire dcwd_clk_cfg_t clk_cfg,
  input wire dcwd_pll_cfg_t pll_cfg,
  input wire dcwd_pin_cfg_t pin_cfg,
  input wire logic          primary_source_conflict,
  input wire logic [15:0]   user_identifier
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [31:0] w1 = clock_config_word_one;
  wire logic [31:0] w2 = pll_config_word_two;
  wire logic [31:0] w3 = pin_and_user_config_word_three;
  // Capture edge, then the decode is one edge behind it
  sequence s_latched; config_valid && !$past(config_valid); endsequence
  sequence s_settled; config_valid && $past(config_valid); endsequence
  a_word_capture: assert property (s_latched |-> w1 == $past(nvm_word_one) && w2 == $past(nvm_word_two)
    && w3 == ($past(nvm_word_three) & W3_IMPL_MASK)) else $error("words not captured at release");
  a_word_hold: assert property (s_settled |-> $stable(w1) && $stable(w2) && $stable(w3))
    else $error("latched words changed");
  a_unimpl_zero: assert property (w3[27:16] == 12'h000) else $error("unimplemented bits not zero");
  a_switch_decode: assert property (s_settled |-> clk_cfg.clock_switch_enable == !w1[15]
    && clk_cfg.fail_safe_monitor_enable == (w1[15:14] == 2'h0)) else $error("switch monitor decode");
  a_bus_divisor: assert property (s_settled |-> clk_cfg.periph_bus_divisor == (4'h1 << w1[13:12]))
    else $error("bus divisor decode");
  a_clock_out: assert property (s_settled |-> clk_cfg.clock_out_active ==
    (!w1[10] && (w1[9:8] == 2'h3 || w1[9:8] == 2'h0))) else $error("clock out decode");
  a_osc_fields: assert property (s_settled |-> clk_cfg.startup_clock_source == w1[2:0]
    && clk_cfg.primary_osc_mode == w1[9:8] && clk_cfg.two_speed_startup_enable == w1[7]
    && clk_cfg.secondary_osc_enable == w1[5]) else $error("oscillator fields decode");
  a_source_conflict: assert property (s_settled |-> primary_source_conflict ==
    (w1[2:1] == 2'h1 && w1[9:8] == 2'h3)) else $error("conflict flag");
  a_pll_divisor: assert property (s_settled |-> pll_cfg.main_pll_out_divisor ==
    (w2[18:16] == 3'h7 ? 9'h100 : (9'h001 << w2[18:16]))) else $error("pll divisor decode");
  a_usb_pll_on: assert property (s_settled |-> pll_cfg.usb_pll_enable == !w2[15])
    else $error("usb pll enable decode");
  a_pin_owner: assert property (s_settled |-> pin_cfg == {w3[31:28], w3[15:0]}
    && user_identifier == w3[15:0]) else $error("pin owner decode");
endmodule // dcwd_decode_monitor
bind dcwd_decode dcwd_decode_monitor u_mon (.clk(clk), .rst(rst), .nvm_word_one(nvm_word_one),
  .nvm_word_two(nvm_word_two), .nvm_word_three(nvm_word_three), .clock_config_word_one(clock_config_word_one),
  .pll_config_word_two(pll_config_word_two), .pin_and_user_config_word_three(pin_and_user_config_word_three),
  .config_valid(config_valid), .clk_cfg(clk_cfg), .pll_cfg(pll_cfg), .pin_cfg(pin_cfg),
  .primary_source_conflict(primary_source_conflict), .user_identifier(user_identifier));
`default_nettype wire

// >>> test/dcwd_decode_tb.sv
// Testbench for the configuration word decoder: eight reset cycles, one per code.
// Assumes the decoder alone; words and reset driven at the falling edge.
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module dcwd_decode_tb;
  import dcwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [31:0]   w1 = 32'hFFFFFFFF;
  logic [31:0]   w2 = 32'hFFFFFFFF;
  logic [31:0]   w3 = 32'hFFFFFFFF;
  logic [31:0]   q1, q2, q3;
  logic          valid, conflict;
  logic [15:0]   uid;
  dcwd_clk_cfg_t ccfg;
  dcwd_pll_cfg_t pcfg;
  dcwd_pin_cfg_t ncfg;
  int            num_errors = 0;
  int            check_count = 0;
  int            cycles = 0;
  int            mul_tab [8] = '{15, 16, 17, 18, 19, 20, 21, 24};
  int            udiv_tab [8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  dcwd_decode dut (.clk(clk), .rst(rst), .nvm_word_one(w1), .nvm_word_two(w2), .nvm_word_three(w3),
    .clock_config_word_one(q1), .pll_config_word_two(q2), .pin_and_user_config_word_three(q3),
    .config_valid(valid), .clk_cfg(ccfg), .pll_cfg(pcfg), .pin_cfg(ncfg),
    .primary_source_conflict(conflict), .user_identifier(uid));
  always #50 clk = ~clk;
  // Ceiling well above the fifty-eight cycles the cases need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One reset cycle; every field takes bits of code i, reserved bits programmed as ones
  task automatic run_case(input logic [2:0] i);
    logic [31:0] e1, e2, e3;
    e1 = {16'hFFFF, i[2:1], i[1:0], 1'b1, i[2], i[1:0], i[0], 1'b1, i[1], 2'h3, i};
    e2 = {13'h1FFF, i, i[0], 4'hF, i, 1'b1, i, 1'b1, 3'h7};
    e3 = {~i[0], i[1], i[2], i[0], 12'hFFF, 13'h1A5, i};
    @(negedge clk);
    rst = 1'b1;
    w1 = e1;
    w2 = e2;
    w3 = e3;
    @(negedge clk);
    `CHK("valid in reset", 1'b0, valid)
    `CHK("word one in reset", WORD_RESET, q1)
    `CHK("word three in reset", WORD3_RESET, q3)
    `CHK("pll cfg in reset", 19'h00000, pcfg)
    rst = 1'b0;
    @(negedge clk);
    `CHK("valid after edge one", 1'b1, valid)
    @(negedge clk);
    `CHK("word one", e1, q1)
    `CHK("word two", e2, q2)
    `CHK("word three", e3 & 32'hF000FFFF, q3)
    `CHK("multiplier", 5'(mul_tab[i]), pcfg.main_pll_multiplier)
    `CHK("usb divider", 4'(udiv_tab[i]), pcfg.usb_pll_input_divider)
    `CHK("user id", e3[15:0], uid)
    `CHK("switch enable", ~i[2], ccfg.clock_switch_enable)
    `CHK("clock out", ~i[2] & ~(i[1] ^ i[0]), ccfg.clock_out_active)
    `CHK("conflict", i == 3'h3, conflict)
    // Later changes on the stored words must not reach the outputs
    w1 = ~e1;
    w2 = ~e2;
    w3 = ~e3;
    repeat (3) @(negedge clk);
    `CHK("word one held", e1, q1)
    `CHK("word three held", e3 & 32'hF000FFFF, q3)
    `CHK("source held", dcwd_src_t'(i), ccfg.startup_clock_source)
    $display("case %0d done", i);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      run_case(3'(k));
    end
    report_and_stop();
  end
endmodule // dcwd_decode_tb
`default_nettype wire
